// ---- ocd_decode.sv ----
// opcode decoder and executor for the instruction set tail
// assumes a program/data memory answering reads one cycle after memRead
`timescale 1ns/1ps
`include "ocd_defs.svh"
module ocd_decode
    import ocd_pkg::*;
(
    // clock and reset
    input wire logic sys_clk,
    input wire logic reset_n,
    input wire logic clkEn,
    // memory
    output logic [15:0] memAddr,
    output logic memRead,
    input wire logic [7:0] memData,
    // interrupt request
    input wire logic irqReq,
    // state view
    output logic [7:0] accOut,
    output logic [7:0] idxOut,
    output logic [7:0] ccrOut,
    output logic [15:0] pcOut,
    output logic waiting,
    output logic illegal,
    output logic instrDone
);
    ////////////////////////////////////////////////////////////////////
    ocd_state_t state_reg, state_next;
    logic [7:0] op_reg, b1_reg;
    logic [15:0] pc_reg, ea_reg;
    logic [7:0] acc_reg, idx_reg, ccr_reg;
    logic [3:0] cyc_reg;
    logic irqS1_reg, irqS2_reg;
    logic [15:0] addrOut_reg;
    logic rdOut_reg, doneOut_reg;
    logic waitOut_reg, illegalOut_reg;

    wire [3:0] opCol = memData[7:4];
    wire [3:0] opRow = memData[3:0];
    wire isTst = (opRow == 4'hd) && (opCol >= 4'h3) && (opCol <= 4'h7);
    wire isXfer = (memData == `OCD_OP_XFER);
    wire isWait = (memData == `OCD_OP_WAIT);
    wire isBrBit = (opCol == 4'h0);

    // only the tail rows and bit branch column 0 are decoded here; rest is illegal
    wire isLegal = isTst || isXfer || isWait || isBrBit;
    wire [3:0] tstCyc = (opCol == 4'h3) ? `OCD_CYC_TST_DIR :
                        (opCol == 4'h6) ? `OCD_CYC_TST_IX1 :
                        (opCol == 4'h7) ? `OCD_CYC_TST_IX : `OCD_CYC_TST_INH;
    // cycles left once the operand bytes are in
    wire [3:0] cycLeft = isXfer ? `OCD_CYC_XFER - 4'h1 :
                         (opCol == 4'h3 || opCol == 4'h6) ? tstCyc - 4'h3 :
                         (opCol == 4'h7) ? tstCyc - 4'h2 : tstCyc - 4'h1;
    wire [7:0] tstVal = memData - 8'h00;
    wire [7:0] tstReg = (op_reg == `OCD_OP_TST_ACC) ? acc_reg : idx_reg;
    wire [7:0] tstOpnd = (state_reg == ST_READ) ? tstVal : tstReg;
    wire [7:0] ccrTst = {ccr_reg[7:3], tstOpnd[7], tstOpnd == 8'h00,
                         ccr_reg[0]};

    wire [15:0] eaIx1 = {8'h00, idx_reg} + {8'h00, memData};
    // long index address, high byte held in b1
    wire [15:0] eaIx2 = {b1_reg, memData} + {8'h00, idx_reg};
    wire [15:0] eaExt = {b1_reg, memData};

    wire [15:0] brTgt = pc_reg + 16'h0001 + {{8{memData[7]}}, memData};
    wire bitSet = b1_reg[op_reg[3:1]];
    wire brTaken = bitSet ^ op_reg[0];
    wire opCol0 = (op_reg[7:4] == 4'h0);
    wire irqSeen = irqS2_reg;

    ////////////////////////////////////////////////////////////////////
    always_comb begin
        state_next = state_reg;
        unique case (state_reg)
            ST_FETCH: begin
                if (!isLegal) state_next = ST_ILLEGAL;
                else if (isWait) state_next = ST_WAITING;
                else if (isXfer || (isTst && (opCol == 4'h4 || opCol == 4'h5)))
                    state_next = ST_EXEC;
                else if (opCol == 4'h7) state_next = ST_READ;
                else state_next = ST_OPND1;
            end
            ST_OPND1: state_next = opCol0 ? ST_READ : ST_READ;
            ST_OPND2: state_next = ST_EXEC;
            ST_READ: state_next = opCol0 ? ST_OPND2 : ST_EXEC;
            ST_EXEC: state_next = (cyc_reg <= 4'h1) ? ST_FETCH : ST_EXEC;
            ST_WAITING: state_next = irqSeen ? ST_FETCH : ST_WAITING;
            ST_ILLEGAL: state_next = ST_ILLEGAL;
        endcase
    end

    always_ff @(posedge sys_clk or negedge reset_n) begin
        if (!reset_n) begin
            irqS1_reg <= 1'b0;
            irqS2_reg <= 1'b0;
        end else if (clkEn) begin
            irqS1_reg <= irqReq;
            irqS2_reg <= irqS1_reg;
        end
    end

    always_ff @(posedge sys_clk or negedge reset_n) begin
        if (!reset_n) begin
            state_reg <= ST_FETCH;
            op_reg <= 8'h00;
            b1_reg <= 8'h00;
            pc_reg <= 16'h0000;
            ea_reg <= 16'h0000;
            acc_reg <= 8'h00;
            idx_reg <= 8'h00;
            ccr_reg <= `OCD_CCR_RST;
            cyc_reg <= 4'h0;
            addrOut_reg <= 16'h0000;
            rdOut_reg <= 1'b1;
            doneOut_reg <= 1'b0;
        end else if (clkEn) begin
            state_reg <= state_next;
            doneOut_reg <= 1'b0;
            rdOut_reg <= 1'b0;
            unique case (state_reg)
                ST_FETCH: begin
                    op_reg <= memData;
                    pc_reg <= pc_reg + 16'h0001;
                    cyc_reg <= cycLeft;
                    rdOut_reg <= 1'b1;
                    addrOut_reg <= (opCol == 4'h7) ? {8'h00, idx_reg} :
                                   pc_reg + 16'h0001;
                    if (isWait) ccr_reg[`OCD_CC_I] <= 1'b0;
                end
                ST_OPND1: begin
                    b1_reg <= memData;
                    pc_reg <= pc_reg + 16'h0001;
                    rdOut_reg <= 1'b1;
                    if (op_reg[7:4] == 4'h6) addrOut_reg <= eaIx1;
                    else addrOut_reg <= {8'h00, memData};
                    ea_reg <= addrOut_reg;
                end
                ST_READ: begin
                    if (opCol0) begin
                        b1_reg <= memData;
                        rdOut_reg <= 1'b1;
                        addrOut_reg <= pc_reg;
                    end
                    else ccr_reg <= ccrTst;
                end
                ST_OPND2: begin
                    pc_reg <= pc_reg + 16'h0001;
                    ccr_reg[`OCD_CC_C] <= bitSet;
                    if (brTaken) pc_reg <= brTgt;
                    ea_reg <= eaIx2 ^ eaIx2 ^ eaExt;
                end
                ST_EXEC: begin
                    cyc_reg <= cyc_reg - 4'h1;
                    if (cyc_reg <= 4'h1) begin
                        doneOut_reg <= 1'b1;
                        rdOut_reg <= 1'b1;
                        addrOut_reg <= pc_reg;
                        if (op_reg == `OCD_OP_XFER) acc_reg <= idx_reg;
                        else if (op_reg[7:4] == 4'h4 || op_reg[7:4] == 4'h5)
                            ccr_reg <= ccrTst;
                    end
                end
                ST_WAITING: begin
                    if (irqSeen) begin
                        doneOut_reg <= 1'b1;
                        rdOut_reg <= 1'b1;
                        addrOut_reg <= pc_reg;
                    end
                end
                ST_ILLEGAL: begin
                end
            endcase
        end
    end

    // status flags registered from the next state
    always_ff @(posedge sys_clk or negedge reset_n) begin
        if (!reset_n) begin
            waitOut_reg <= 1'b0;
            illegalOut_reg <= 1'b0;
        end else if (clkEn) begin
            waitOut_reg <= (state_next == ST_WAITING);
            illegalOut_reg <= (state_next == ST_ILLEGAL);
        end
    end

    ////////////////////////////////////////////////////////////////////
    assign memAddr = addrOut_reg;
    assign memRead = rdOut_reg;
    assign accOut = acc_reg;
    assign idxOut = idx_reg;
    assign ccrOut = ccr_reg;
    assign pcOut = pc_reg;
    assign waiting = waitOut_reg;
    assign illegal = illegalOut_reg;
    assign instrDone = doneOut_reg;
endmodule : ocd_decode

// ---- ocd_defs.svh ----
// constants for the opcode decode tail: opcodes, flag positions, cycles
// assumes nothing beyond a single include per compile unit
`ifndef OCD_DEFS_SVH
`define OCD_DEFS_SVH
`define OCD_OP_TST_DIR 8'h3d
`define OCD_OP_TST_ACC 8'h4d
`define OCD_OP_TST_IDX 8'h5d
`define OCD_OP_TST_IX1 8'h6d
`define OCD_OP_TST_IX 8'h7d
`define OCD_OP_XFER 8'h9f
`define OCD_OP_WAIT 8'h8f
`define OCD_CC_H 4
`define OCD_CC_I 3
`define OCD_CC_N 2
`define OCD_CC_Z 1
`define OCD_CC_C 0
`define OCD_CCR_RST 8'he8
`define OCD_CYC_XFER 4'h2
`define OCD_CYC_WAIT 4'h2
`define OCD_CYC_TST_DIR 4'h4
`define OCD_CYC_TST_INH 4'h3
`define OCD_CYC_TST_IX1 4'h5
`define OCD_CYC_TST_IX 4'h4
`endif

// ---- ocd_pkg.sv ----
// types for the opcode decode tail
// assumes ocd_defs.svh is on the include path
package ocd_pkg;
    typedef enum logic [2:0] {
        ADDR_INH, ADDR_IMM, ADDR_DIR, ADDR_EXT,
        ADDR_IX2, ADDR_IX1, ADDR_IX, ADDR_REL
    } ocd_mode_t;
    typedef enum {
        ST_FETCH, ST_OPND1, ST_OPND2, ST_READ, ST_EXEC, ST_WAITING, ST_ILLEGAL
    } ocd_state_t;
endpackage : ocd_pkg

// ---- ocd_decode_assertions.sv ----
// port checks for the opcode decode tail
// assumes binding onto every ocd_decode instance
`timescale 1ns/1ps
module ocd_decode_chk (
    // clock, reset and interrupt request
    input wire logic sys_clk,
    input wire logic reset_n,
    input wire logic irqReq,
    // state view
    input wire logic [7:0] accOut,
    input wire logic [7:0] idxOut,
    input wire logic [7:0] ccrOut,
    input wire logic [15:0] pcOut,
    input wire logic waiting,
    input wire logic illegal,
    input wire logic instrDone
);
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (!reset_n);
    chk_half_carry_kept: assert property ($stable(ccrOut[4]))
        else $error("half carry changed");
    chk_acc_from_index: assert property (
        $changed(accOut) |-> accOut == idxOut)
        else $error("accumulator not loaded from index");
    chk_xfer_flags_kept: assert property (
        $changed(accOut) |-> $stable(ccrOut))
        else $error("flags moved on transfer");
    chk_index_untouched: assert property ($stable(idxOut))
        else $error("index register changed");
    chk_wait_mask_clear: assert property (waiting |-> !ccrOut[3])
        else $error("mask set while waiting");
    chk_wait_holds_on: assert property (
        (waiting && !irqReq) [*3] |=> waiting)
        else $error("left wait with no interrupt");
    chk_wait_pc_frozen: assert property (
        waiting ##1 waiting |-> $stable(pcOut))
        else $error("pc moved while waiting");
    chk_illegal_sticky: assert property (illegal |=> illegal)
        else $error("illegal flag dropped");
    chk_illegal_halts: assert property (
        illegal |=> $stable(pcOut) && !instrDone)
        else $error("decoder ran after illegal opcode");
endmodule : ocd_decode_chk
////////////////////////////////////////////////////////////////////////////////
bind ocd_decode ocd_decode_chk ocd_decode_chk_i (.sys_clk, .reset_n,
    .irqReq, .accOut, .idxOut, .ccrOut, .pcOut, .waiting, .illegal,
    .instrDone);

// ---- tb_top.sv ----
// directed bench for the opcode decode tail
// assumes a small program image answered one cycle after each read
`timescale 1ns/1ps
`include "ocd_defs.svh"
module tb_top;
    logic sys_clk = 0;
    logic reset_n = 0;
    logic irqReq = 0;
    logic clkEn = 1;
    logic [7:0] memData = 8'h00;
    logic [15:0] memAddr, pcOut, pcHeld;
    logic memRead, waiting, illegal, instrDone;
    logic [7:0] accOut, idxOut, ccrOut;
    logic [7:0] mem [0:255];
    int n_mismatch = 0;
    int comparisons = 0;
    int cyc = 0;
    logic [15:0] gap;
    always #25 sys_clk = ~sys_clk;
    ocd_decode ocd_decode_i (.sys_clk, .reset_n, .clkEn, .memAddr,
        .memRead, .memData, .irqReq, .accOut, .idxOut, .ccrOut, .pcOut,
        .waiting, .illegal, .instrDone);
    // memory answers while memRead is high, else shows junk
    always @(posedge sys_clk) begin
        #1;
        memData = memRead ? mem[memAddr[7:0]] : ~memData;
    end
    always @(posedge sys_clk) begin
        cyc <= cyc + 1;
        if (cyc == 3000) begin
            n_mismatch++;
            give_verdict();
        end
    end
    ////////////////////////////////////////////////////////////////////////////
    task automatic tick(int n);
        repeat (n) @(posedge sys_clk);
        #1;
    endtask : tick
    task automatic check(string what, logic [15:0] seen, logic [15:0] exp);
        comparisons++;
        if (seen !== exp) begin
            n_mismatch++;
            $display("mismatch %s expected %h seen %h", what, exp, seen);
        end
    endtask : check
    task automatic wait_done(output logic [15:0] n);
        n = 16'h0000;
        do begin
            tick(1);
            n++;
        end while (instrDone !== 1'b1 && n < 16'h0040);
    endtask : wait_done
    task automatic give_verdict();
        $display("comparisons %0d mismatches %0d", comparisons, n_mismatch);
        if (n_mismatch == 0 && comparisons > 0) $display("bench passed");
        else $display("bench failed");
        $finish;
    endtask : give_verdict
    ////////////////////////////////////////////////////////////////////////////
    task automatic t_test_flags();
        wait_done(gap);
        check("direct test cycles", gap, 16'h0004);
        check("ccr after direct test", ccrOut, 16'h00ec);
        wait_done(gap);
        check("acc test cycles", gap, 16'h0003);
        check("ccr after acc test", ccrOut, 16'h00ea);
        $display("test flags done");
    endtask : t_test_flags
    task automatic t_xfer();
        wait_done(gap);
        check("xfer done spacing", gap, 16'h0002);
        check("acc after xfer", accOut, 16'h0000);
        check("index after xfer", idxOut, 16'h0000);
        check("ccr after xfer", ccrOut, 16'h00ea);
        $display("test xfer done");
    endtask : t_xfer
    task automatic t_wait();
        while (waiting !== 1'b1) tick(1);
        check("mask in wait", ccrOut, 16'h00e2);
        tick(6);
        check("still waiting", waiting, 1'b1);
        clkEn = 0;
        irqReq = 1;
        tick(6);
        check("frozen in wait", waiting, 1'b1);
        clkEn = 1;
        wait_done(gap);
        check("woken", waiting, 1'b0);
        irqReq = 0;
        $display("test wait done");
    endtask : t_wait
    task automatic t_modes();
        wait_done(gap);
        check("indexed test cycles", gap, 16'h0004);
        check("ccr after indexed test", ccrOut, 16'h00e0);
        wait_done(gap);
        check("short offset cycles", gap, 16'h0005);
        check("ccr after short offset", ccrOut, 16'h00e4);
        wait_done(gap);
        check("index test cycles", gap, 16'h0003);
        check("ccr after index test", ccrOut, 16'h00e2);
        wait_done(gap);
        check("pc after bit branch", pcOut, 16'h000e);
        check("carry from bit", ccrOut, 16'h00e3);
        $display("test modes done");
    endtask : t_modes
    task automatic t_illegal();
        while (illegal !== 1'b1) tick(1);
        pcHeld = pcOut;
        check("pc at halt", pcHeld, 16'h000f);
        tick(8);
        check("illegal held", illegal, 1'b1);
        check("pc frozen", pcOut, pcHeld);
        $display("test illegal done");
    endtask : t_illegal
    initial begin
        foreach (mem[i]) mem[i] = 8'h42;
        mem[0] = `OCD_OP_TST_DIR;
        mem[1] = 8'h20;
        mem[2] = `OCD_OP_TST_ACC;
        mem[3] = `OCD_OP_XFER;
        mem[4] = `OCD_OP_WAIT;
        mem[5] = `OCD_OP_TST_IX;
        mem[6] = `OCD_OP_TST_IX1;
        mem[7] = 8'h20;
        mem[8] = `OCD_OP_TST_IDX;
        mem[9] = 8'h0e;
        mem[10] = 8'h20;
        mem[11] = 8'h02;
        mem[12] = `OCD_OP_XFER;
        mem[13] = `OCD_OP_XFER;
        mem[8'h20] = 8'h80;
        tick(16);
        reset_n = 1;
        t_test_flags();
        t_xfer();
        t_wait();
        t_modes();
        t_illegal();
        give_verdict();
    end
endmodule : tb_top
